/* File: lcap_regs.sv */
// Notes on behaviour
// - speed field bits 3:0, resets to 1
// - width field bits 9:4, legal lane codes
// - reserved width code trains one lane
// - width loaded from physical port width
// - low-power support reads constant 3
// - separate clocks: short latency code 5
// - common clock: short latency code 3
// - deep latency defaults to code 2
// - clock removal bit resets to zero
// - surprise-down: downstream one, upstream zero
// - link-active: downstream one, upstream zero
// - bandwidth notify: downstream one, upstream zero
// - older protocol mode: bandwidth notify zero
// - port number fixed in bits 31:24
// - link control bit 6 selects common clock
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
module lcap_regs
    import lcap_pkg::*;
#(
    parameter logic [7:0] PORT_ID = 8'h00,
    parameter bit IS_UPSTREAM = 1'b0
)(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [11:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    input wire logic [5:0] physWidth,
    input wire logic legacyMode,
    output logic [5:0] trainWidth,
    output logic sharedRefclkSelect
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [3:0] speed_r, speed_nxt;
    logic [5:0] width_r, width_nxt;
    logic [2:0] deepLat_r, deepLat_nxt;
    logic clkRm_r, clkRm_nxt;
    logic sdn_r, sdn_nxt;
    logic lar_r, lar_nxt;
    logic bwn_r, bwn_nxt;
    logic shClk_r, shClk_nxt;
    logic unlock_r, unlock_nxt;
    logic init_r, init_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] rdData_r, rdData_nxt;
    logic [5:0] trainWidth_r, trainWidth_nxt;
    logic [5:0] widthChecked;
    logic [31:0] capWord;
    logic wrCap;
    logic wrLock;
    logic wrCtl;
    logic req;

    lcap_width_check u_width_check (
        .widthCode(width_r),
        .widthUsed(widthChecked)
    );

    // ------------------------------------------------------------
    // capability word assembly
    // ------------------------------------------------------------
    always_comb begin
        capWord = 32'h0000_0000;
        capWord[SPD_HI:SPD_LO] = speed_r;
        capWord[WID_HI:WID_LO] = width_r;
        capWord[LPS_HI:LPS_LO] = LPS_VAL;
        capWord[SEL_HI:SEL_LO] = shClk_r ? SEL_COM : SEL_SEP;
        capWord[DEL_HI:DEL_LO] = deepLat_r;
        capWord[CLKRM_BIT] = clkRm_r;
        capWord[SDN_BIT] = sdn_r;
        capWord[LAR_BIT] = lar_r;
        capWord[BWN_BIT] = bwn_r;
        capWord[RSV_HI:RSV_LO] = 2'h0;
        capWord[PID_HI:PID_LO] = PORT_ID;
    end

    // ------------------------------------------------------------
    // bus decode, one wait cycle then acknowledge
    // ------------------------------------------------------------
    always_comb begin
        req = (avsRead | avsWrite) & ~ack_r;
        wrCap = avsWrite & req & (avsAddress == LCAP_OFS);
        wrCtl = avsWrite & req & (avsAddress == LCTL_OFS);
        wrLock = avsWrite & req & (avsAddress == LOCK_OFS);
    end

    always_comb begin
        speed_nxt = speed_r;
        width_nxt = width_r;
        deepLat_nxt = deepLat_r;
        clkRm_nxt = clkRm_r;
        sdn_nxt = sdn_r;
        lar_nxt = lar_r;
        bwn_nxt = bwn_r;
        shClk_nxt = shClk_r;
        unlock_nxt = unlock_r;
        init_nxt = 1'b1;
        ack_nxt = req;
        rdData_nxt = rdData_r;
        trainWidth_nxt = widthChecked;
        if (!init_r) begin
            width_nxt = physWidth;
            bwn_nxt = ~IS_UPSTREAM & ~legacyMode;
        end
        if (wrCap && unlock_r) begin
            if (avsByteEnable[0]) begin
                speed_nxt = avsWriteData[SPD_HI:SPD_LO];
                width_nxt[3:0] = avsWriteData[7:4];
            end
            if (avsByteEnable[1]) begin
                width_nxt[5:4] = avsWriteData[WID_HI:8];
            end
            if (avsByteEnable[2]) begin
                deepLat_nxt[2:1] = avsWriteData[DEL_HI:16];
                clkRm_nxt = avsWriteData[CLKRM_BIT];
                sdn_nxt = avsWriteData[SDN_BIT];
                lar_nxt = avsWriteData[LAR_BIT];
                bwn_nxt = avsWriteData[BWN_BIT];
            end
            if (avsByteEnable[1]) begin
                deepLat_nxt[0] = avsWriteData[DEL_LO];
            end
        end
        if (wrCtl && avsByteEnable[0]) begin
            shClk_nxt = avsWriteData[SHCLK_BIT];
        end
        if (wrLock && avsByteEnable[0]) begin
            unlock_nxt = avsWriteData[0];
        end
        if (avsRead && req) begin
            case (avsAddress)
                LCAP_OFS: rdData_nxt = capWord;
                LCTL_OFS: rdData_nxt = {25'h0, shClk_r, 6'h00};
                LOCK_OFS: rdData_nxt = {31'h0, unlock_r};
                default: rdData_nxt = RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            speed_r <= SPD_RST;
            width_r <= WID_X1;
            deepLat_r <= DEL_RST;
            clkRm_r <= 1'b0;
            sdn_r <= ~IS_UPSTREAM;
            lar_r <= ~IS_UPSTREAM;
            bwn_r <= ~IS_UPSTREAM;
            shClk_r <= 1'b0;
            unlock_r <= 1'b0;
            init_r <= 1'b0;
            ack_r <= 1'b0;
            rdData_r <= 32'h0000_0000;
            trainWidth_r <= WID_X1;
        end else begin
            speed_r <= speed_nxt;
            width_r <= width_nxt;
            deepLat_r <= deepLat_nxt;
            clkRm_r <= clkRm_nxt;
            sdn_r <= sdn_nxt;
            lar_r <= lar_nxt;
            bwn_r <= bwn_nxt;
            shClk_r <= shClk_nxt;
            unlock_r <= unlock_nxt;
            init_r <= init_nxt;
            ack_r <= ack_nxt;
            rdData_r <= rdData_nxt;
            trainWidth_r <= trainWidth_nxt;
        end
    end

    assign avsReadData = rdData_r;
    assign avsWaitRequest = ~ack_r;
    assign trainWidth = trainWidth_r;
    assign sharedRefclkSelect = shClk_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_speed_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(init_r) |-> speed_r == SPD_RST)
        else $error("speed field not at reset value");
    a_width_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !init_r |=> width_r == $past(physWidth))
        else $error("width not loaded from port");
    a_width_fallback: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (width_r != 6'h01 && width_r != 6'h02 && width_r != 6'h04 && width_r != 6'h08
        && width_r != 6'h0c && width_r != 6'h10 && width_r != 6'h20) |=> trainWidth == WID_X1)
        else $error("reserved width not forced to one lane");
    a_lowpow_const: assert property (@(posedge clk_sys) disable iff (!rst_b)
        avsRead && req && avsAddress == LCAP_OFS |=> avsReadData[LPS_HI:LPS_LO] == LPS_VAL)
        else $error("low-power support not 3");
    a_short_lat: assert property (@(posedge clk_sys) disable iff (!rst_b)
        avsRead && req && avsAddress == LCAP_OFS && shClk_r
        |=> avsReadData[SEL_HI:SEL_LO] == SEL_COM)
        else $error("common clock latency wrong");
    a_short_sep: assert property (@(posedge clk_sys) disable iff (!rst_b)
        avsRead && req && avsAddress == LCAP_OFS && !shClk_r
        |=> avsReadData[SEL_HI:SEL_LO] == SEL_SEP)
        else $error("separate clock latency wrong");
    a_rsv_pid: assert property (@(posedge clk_sys) disable iff (!rst_b)
        avsRead && req && avsAddress == LCAP_OFS
        |=> avsReadData[PID_HI:RSV_LO] == {PORT_ID, 2'h0})
        else $error("port id or reserved bits wrong");
    a_lock_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        init_r && !unlock_r |=> $stable(speed_r) && $stable(width_r) && $stable(bwn_r))
        else $error("locked field changed");
    a_bus_ack: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
        else $error("no acknowledge after one cycle");
endmodule // lcap_regs

/* File: lcap_pkg.sv */
package lcap_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] LCAP_OFS = 12'h04c;
    localparam logic [11:0] LCTL_OFS = 12'h050;
    localparam logic [11:0] LOCK_OFS = 12'h060;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SPD_LO = 0;
    localparam int SPD_HI = 3;
    localparam int WID_LO = 4;
    localparam int WID_HI = 9;
    localparam int LPS_LO = 10;
    localparam int LPS_HI = 11;
    localparam int SEL_LO = 12;
    localparam int SEL_HI = 14;
    localparam int DEL_LO = 15;
    localparam int DEL_HI = 17;
    localparam int CLKRM_BIT = 18;
    localparam int SDN_BIT = 19;
    localparam int LAR_BIT = 20;
    localparam int BWN_BIT = 21;
    localparam int RSV_LO = 22;
    localparam int RSV_HI = 23;
    localparam int PID_LO = 24;
    localparam int PID_HI = 31;
    localparam int SHCLK_BIT = 6;

    // ------------------------------------------------------------
    // reset and fixed values
    // ------------------------------------------------------------
    localparam logic [3:0] SPD_RST = 4'h1;
    localparam logic [1:0] LPS_VAL = 2'h3;
    localparam logic [2:0] SEL_SEP = 3'h5;
    localparam logic [2:0] SEL_COM = 3'h3;
    localparam logic [2:0] DEL_RST = 3'h2;
    localparam logic [5:0] WID_X1 = 6'h01;
    localparam logic [31:0] LCTL_MASK = 32'h0000_0040;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
    localparam int SEL_PORT_WIDTH = 6;
endpackage

/* File: lcap_width_check.sv */
`timescale 1ns/1ps
module lcap_width_check
    import lcap_pkg::*;
(
    input wire logic [5:0] widthCode,
    output logic [5:0] widthUsed
);
    // ------------------------------------------------------------
    // legal lane counts, anything else falls back to one lane
    // ------------------------------------------------------------
    always_comb begin
        case (widthCode)
            6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20: widthUsed = widthCode;
            default: widthUsed = WID_X1;
        endcase
    end
endmodule // lcap_width_check

/* File: test_lcap_regs.sv */
`timescale 1ns/1ps
module test_lcap_regs
    import lcap_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [7:0] PID = 8'h04;
    logic clk_sys, rst_b, avsRead, avsWrite, avsWaitRequest, legacyMode, sharedRefclkSelect;
    logic [11:0] avsAddress;
    logic [31:0] avsWriteData, avsReadData, rd, exp, wd;
    logic [3:0] avsByteEnable;
    logic [5:0] physWidth, trainWidth, pw, code;
    logic sh;
    int bad_count, checks, seed, cyc;
    logic [5:0] legal [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20};
    logic [5:0] corner [4] = '{6'h00, 6'h0c, 6'h20, 6'h3f};

    lcap_regs #(.PORT_ID(PID), .IS_UPSTREAM(1'b0)) u_lcap_regs (
        .clk_sys(clk_sys), .rst_b(rst_b), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .physWidth(physWidth),
        .legacyMode(legacyMode), .trainWidth(trainWidth),
        .sharedRefclkSelect(sharedRefclkSelect)
    );

    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    function automatic logic [31:0] cap_word(input logic [5:0] w, input logic s, input logic l);
        return {PID, 2'h0, ~l, 1'b1, 1'b1, 1'b0, DEL_RST, s ? SEL_COM : SEL_SEP, LPS_VAL, w,
                SPD_RST};
    endfunction

    function automatic logic [5:0] train_of(input logic [5:0] c);
        return (c inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20}) ? c : WID_X1;
    endfunction

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        checks++;
        if (seen !== want) begin
            bad_count++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, want);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one access; entered just after a rising edge
    task automatic bus(input bit wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWriteData <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 50);
        if (n >= 50) check(1, 0, "no answer");
        q = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic do_reset(input logic l, input logic [5:0] w);
        rst_b <= 1'b0;
        legacyMode <= l;
        physWidth <= w;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------
    // clock and timeout
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            print_verdict;
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 13935;
        rst_b = 1'b0;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsAddress = 12'h000;
        avsWriteData = 32'h0000_0000;
        avsByteEnable = 4'hf;
        legacyMode = 1'b0;
        physWidth = 6'h01;
        pw = legal[$unsigned($random(seed)) % 7];
        do_reset(1'b0, pw);
        bus(0, LCAP_OFS, 32'h0, rd);
        check(rd, cap_word(pw, 1'b0, 1'b0), "cap reset");
        check(32'(trainWidth), 32'(pw), "train init");
        bus(0, LCTL_OFS, 32'h0, rd);
        check(rd, 32'h0, "ctl reset");
        bus(1, LCAP_OFS, ~cap_word(pw, 1'b0, 1'b0), rd);
        bus(0, LCAP_OFS, 32'h0, rd);
        check(rd, cap_word(pw, 1'b0, 1'b0), "locked write");
        bus(1, 12'h100, 32'($random(seed)), rd);
        bus(0, 12'h100, 32'h0, rd);
        check(rd, RD_UNMAPPED, "unmapped");
        bus(1, LOCK_OFS, 32'h1, rd);
        for (int i = 0; i < 16; i++) begin
            code = (i < 4) ? corner[i] : 6'($random(seed));
            sh = 1'($random(seed));
            wd = 32'($random(seed));
            wd[SHCLK_BIT] = sh;
            bus(1, LCTL_OFS, wd, rd);
            check(32'(sharedRefclkSelect), 32'(sh), "shared clk");
            bus(0, LCTL_OFS, 32'h0, rd);
            check(rd, wd & LCTL_MASK, "ctl read");
            exp = cap_word(code, sh, 1'b0);
            bus(1, LCAP_OFS, exp | 32'hffc0_7c00, rd);
            bus(0, LCAP_OFS, 32'h0, rd);
            check(rd, exp, "cap override");
            check(32'(trainWidth), 32'(train_of(code)), "train width");
        end
        bus(1, LOCK_OFS, 32'h0, rd);
        bus(1, LCAP_OFS, 32'h0, rd);
        bus(0, LCAP_OFS, 32'h0, rd);
        check(rd, exp, "relocked");
        do_reset(1'b1, pw);
        bus(0, LCAP_OFS, 32'h0, rd);
        check(rd, cap_word(pw, 1'b0, 1'b1), "legacy");
        print_verdict;
    end
endmodule // test_lcap_regs
